// ### rtl/perp_lock.sv
// Purpose: Perpendicular mode, config lock, dump byte, write protect.
// Assumes: APB slave, one clock; write protect input is a pin.
// Notes:   Gap2 runs in byte times counted from a start pulse.
`timescale 1ns/1ps
module perp_lock
    import perp_lock_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        write_protect_input_n, // Drive pin, low active
    input  wire logic        pp_write_protect_n,    // Parallel-port drive pin
    output logic             write_protect,         // Effective protect
    output logic             pll_vco_enable,
    output logic             write_gate,
    output logic      [2:0]  precomp_value,         // Applied precomp code
    output logic             fifo_disable_setting,
    output logic      [3:0]  fifo_threshold_setting,
    output logic      [7:0]  precomp_start_track
);
    typedef struct packed {
        logic        write_gate_mode_bit;     // write_gate_mode_bit
        logic        gap;       // Gap mode bit
        logic [3:0]  drv;       // per_drive_perp_select
        logic        lock;      // Config lock
        logic        fifo_dis;
        logic [3:0]  thr;
        logic [7:0]  trk;
        logic        force_wp;  // force_write_protect_bit
        logic        ident;     // Identity select
        logic        enc;       // encoding_mode_bit
        logic [1:0]  rate;
        logic [1:0]  drive;
        logic [2:0]  precomp;   // Programmed precomp code
        op_e         op;
        logic [8:0]  cyc;       // Cycles within a byte
        logic [5:0]  bytes;     // Bytes into Gap2
        logic        vco;
        logic        wgo;
        logic        eff_perp;  // Drive-based perpendicular
        logic [2:0]  pcout;
        logic [1:0]  wp_a;      // Sync stage one
        logic [1:0]  wp_b;      // Sync stage two
        logic        wp;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } st_s;
    st_s q;      // Current state
    st_s next_q; // Next state

    logic       setup;     // APB setup phase
    logic       wr_en;     // Write accepted
    logic       drv_perp;  // Selected drive is perpendicular
    logic       perp_1m;   // Effective 1 Mbps perpendicular
    logic       perp_500k; // Effective 500 Kbps perpendicular
    logic [5:0] gap_len;   // Formatted Gap2 length
    logic [5:0] vco_at;    // VCO enable byte
    logic [5:0] wr_at;     // Gap2 bytes written

    assign setup = psel && !penable;

    assign drv_perp = q.drv[q.drive];

    // Effective mode: global bits win, else per-drive bit and rate
    always_comb begin
        perp_1m   = 1'b0;
        perp_500k = 1'b0;
        if (q.write_gate_mode_bit) begin
            perp_1m   = q.gap;
            perp_500k = !q.gap;
        end else if (!q.gap && drv_perp) begin
            perp_1m   = (q.rate == RATE_1M);
            perp_500k = (q.rate == RATE_500K);
        end
    end

    gap_timer u_gap (
        .pclk      (pclk),
        .presetn   (presetn),
        .perp_1m   (perp_1m),
        .perp_500k (perp_500k),
        .gap_len   (gap_len),
        .vco_at    (vco_at),
        .wr_at     (wr_at)
    );

    // All next-state logic
    always_comb begin
        next_q = q;
        wr_en  = psel && penable && pwrite;
        next_q.pready  = setup;
        next_q.pslverr = 1'b0;
        // Pin synchronisers: stage two reads only stage one
        next_q.wp_a = {pp_write_protect_n, write_protect_input_n};
        next_q.wp_b = q.wp_a;
        next_q.wp = q.force_wp || !q.wp_b[0] || !q.wp_b[1];
        next_q.eff_perp = !q.write_gate_mode_bit && !q.gap && drv_perp;
        next_q.pcout    = next_q.eff_perp ? 3'h0 : q.precomp;
        // Register writes in the access phase
        if (wr_en && q.pready) begin
            case (paddr)
                OFS_PERP: begin
                    next_q.write_gate_mode_bit = pwdata[PB_WRITE_GATE_MODE_BIT];
                    next_q.gap   = pwdata[PB_GAP];
                    if (pwdata[PB_OW]) begin
                        next_q.drv = pwdata[PB_DRV +: 4];
                    end
                end
                OFS_CONFIG: begin
                    next_q.fifo_dis = pwdata[CB_FIFO_DIS];
                    next_q.thr      = pwdata[CB_THR +: 4];
                    next_q.trk      = pwdata[CB_TRK +: 8];
                    next_q.force_wp = pwdata[CB_FORCE_WP];
                    next_q.ident    = pwdata[CB_IDENT];
                    next_q.enc      = pwdata[CB_ENC];
                end
                OFS_LOCK: begin
                    next_q.lock = pwdata[0];
                end
                OFS_CTRL: begin
                    next_q.rate    = pwdata[XB_RATE +: 2];
                    next_q.drive   = pwdata[XB_DRIVE +: 2];
                    next_q.precomp = pwdata[XB_PRECOMP +: 3];
                    if (pwdata[XB_SOFT_RST]) begin
                        next_q.write_gate_mode_bit = 1'b0;
                        next_q.gap   = 1'b0;
                        if (!q.lock) begin
                            next_q.fifo_dis = FIFO_DIS_DEF;
                            next_q.thr      = THR_DEF;
                            next_q.trk      = TRK_DEF;
                        end
                        next_q.op  = OP_IDLE;
                        next_q.vco = 1'b0;
                        next_q.wgo = 1'b0;
                    end else if (pwdata[XB_START_RD]) begin
                        next_q.op    = OP_READ;
                        next_q.bytes = '0;
                        next_q.cyc   = '0;
                    end else if (pwdata[XB_START_WR]) begin
                        next_q.op    = OP_WRITE;
                        next_q.bytes = '0;
                        next_q.cyc   = '0;
                    end
                end
                default: begin
                    // Refused at setup; nothing is stored
                    next_q.pslverr = 1'b0;
                end
            endcase
        end
        // Register reads captured in the setup phase
        if (setup && !pwrite) begin
            case (paddr)
                OFS_PERP:   next_q.prdata = {24'h0, 2'h0, q.drv,
                                             q.gap, q.write_gate_mode_bit};
                OFS_CONFIG: next_q.prdata = {5'h0, q.enc, q.ident,
                                             q.force_wp, q.trk, 4'h0,
                                             q.thr, 7'h0, q.fifo_dis};
                OFS_LOCK:   next_q.prdata = {27'h0, q.lock, 4'h0};
                OFS_CTRL:   next_q.prdata = {17'h0, q.precomp, 6'h0,
                                             q.drive, 1'b0, q.rate, 1'b0};
                OFS_STATUS: next_q.prdata = {26'h0, q.op, q.wp,
                                             q.eff_perp, q.wgo, q.vco};
                OFS_DUMP8:  next_q.prdata = {24'h0, q.lock, 1'b0, q.drv,
                                             q.gap, q.write_gate_mode_bit};
                OFS_GAPCNT: next_q.prdata = {26'h0, q.bytes};
                default:    next_q.prdata = 32'h0;
            endcase
        end else if (setup) begin
            next_q.prdata = 32'h0;
        end
        // Write refusal decided in setup, so it stands with pready
        if (setup && pwrite) begin
            case (paddr)
                OFS_PERP, OFS_CONFIG, OFS_LOCK, OFS_CTRL: begin
                    next_q.pslverr = 1'b0;
                end
                default: begin
                    next_q.pslverr = 1'b1;
                end
            endcase
        end
        // Gap2 byte sequencer
        case (q.op)
            OP_IDLE: begin
                next_q.vco = 1'b0;
                next_q.wgo = 1'b0;
            end
            OP_READ, OP_WRITE: begin
                if (q.cyc == BYTE_CYC - 9'h1) begin
                    next_q.cyc   = '0;
                    next_q.bytes = q.bytes + 6'h1;
                end else begin
                    next_q.cyc = q.cyc + 9'h1;
                end
                if (q.op == OP_READ && q.bytes >= vco_at) begin
                    next_q.vco = 1'b1;
                end
                // write gate point
                // Seven bits, so a late byte count cannot wrap
                if (q.op == OP_WRITE
                    && 7'(q.bytes) + 7'(wr_at) >= 7'(gap_len)) begin
                    next_q.wgo = 1'b1;
                end
                if (q.bytes == VCO_PERP1M + 6'h2) begin
                    next_q.op = OP_IDLE;
                end
            end
            default: next_q.op = OP_IDLE;
        endcase
    end

    // State register; hardware reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q          <= '0;
            q.op       <= OP_IDLE;
            q.fifo_dis <= FIFO_DIS_DEF;
            q.thr      <= THR_DEF;
            q.trk      <= TRK_DEF;
            // Pin stages start unprotected, so no false protect
            q.wp_a     <= '1;
            q.wp_b     <= '1;
        end else begin
            q <= next_q;
        end
    end

    assign prdata                 = q.prdata;
    assign pready                 = q.pready;
    assign pslverr                = q.pslverr;
    assign write_protect          = q.wp;
    assign pll_vco_enable         = q.vco;
    assign write_gate             = q.wgo;
    assign precomp_value          = q.pcout;
    assign fifo_disable_setting   = q.fifo_dis;
    assign fifo_threshold_setting = q.thr;
    assign precomp_start_track    = q.trk;

    a_force_wp: assert property (@(posedge pclk)
        disable iff (!presetn)
        q.force_wp && $stable(q.force_wp) |=> write_protect)
        else $error("forced write protect not active");
    a_precomp_zero: assert property (@(posedge pclk)
        disable iff (!presetn)
        q.eff_perp |-> precomp_value == 3'h0)
        else $error("perpendicular drive got precompensation");
    a_precomp_prog: assert property (@(posedge pclk)
        disable iff (!presetn)
        !q.eff_perp |-> precomp_value == $past(q.precomp))
        else $error("conventional drive precomp wrong");
    a_soft_rst: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_en && q.pready && paddr == OFS_CTRL && pwdata[XB_SOFT_RST]
        |=> !q.write_gate_mode_bit && !q.gap && q.drv == $past(q.drv))
        else $error("soft reset mishandled mode bits");
    a_lock_keep: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_en && q.pready && paddr == OFS_CTRL && pwdata[XB_SOFT_RST]
        && q.lock |=> q.trk == $past(q.trk))
        else $error("locked settings changed by soft reset");
    a_ow_gate: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_en && q.pready && paddr == OFS_PERP && !pwdata[PB_OW]
        |=> $stable(q.drv))
        else $error("drive bits changed without overwrite");
    a_wg_conv: assert property (@(posedge pclk)
        disable iff (!presetn)
        q.op == OP_WRITE && wr_at == WR_NONE && q.bytes < gap_len
        |=> !write_gate)
        else $error("write gate early in conventional mode");
    a_vco_late: assert property (@(posedge pclk)
        disable iff (!presetn)
        q.op == OP_READ && q.bytes < vco_at |=> !pll_vco_enable)
        else $error("VCO enabled too early");
    a_vco_conv: assert property (@(posedge pclk)
        disable iff (!presetn)
        !perp_1m |=> vco_at == VCO_CONV)
        else $error("VCO byte wrong in conventional mode");
    a_vco_perp: assert property (@(posedge pclk)
        disable iff (!presetn)
        perp_1m |=> vco_at == VCO_PERP1M)
        else $error("VCO byte wrong in 1M perpendicular");
    a_wr_1m: assert property (@(posedge pclk)
        disable iff (!presetn)
        perp_1m |=> wr_at == WR_PERP1M)
        else $error("written gap bytes wrong at 1M");
    a_wr_500k: assert property (@(posedge pclk)
        disable iff (!presetn)
        perp_500k |=> wr_at == WR_PERP500K)
        else $error("written gap bytes wrong at 500K");
    a_reserved: assert property (@(posedge pclk)
        disable iff (!presetn)
        !q.write_gate_mode_bit && q.gap |=> wr_at == WR_NONE && gap_len == GAP2_CONV)
        else $error("reserved mode not conventional");
    a_drv_perp: assert property (@(posedge pclk)
        disable iff (!presetn)
        !q.write_gate_mode_bit && !q.gap && drv_perp |=> q.eff_perp)
        else $error("drive bit did not select perpendicular");
    a_drv_rate: assert property (@(posedge pclk)
        disable iff (!presetn)
        !q.write_gate_mode_bit && !q.gap && drv_perp && q.rate == RATE_500K
        |=> wr_at == WR_PERP500K)
        else $error("drive gap bytes ignore data rate");
    a_gbl_override: assert property (@(posedge pclk)
        disable iff (!presetn)
        q.write_gate_mode_bit || q.gap |=> !q.eff_perp)
        else $error("drive bit used under global mode");
    a_unlock_dflt: assert property (@(posedge pclk)
        disable iff (!presetn)
        wr_en && q.pready && paddr == OFS_CTRL && pwdata[XB_SOFT_RST]
        && !q.lock |=> q.trk == TRK_DEF && q.thr == THR_DEF
        && q.fifo_dis == FIFO_DIS_DEF)
        else $error("unlocked soft reset kept settings");
    // Write refusal stands only with ready
    a_err_ready: assert property (@(posedge pclk)
        disable iff (!presetn)
        pslverr |-> pready)
        else $error("error response without ready");
endmodule : perp_lock

// ### rtl/perp_lock_pkg.sv
// Purpose: Constants for the perpendicular-recording and lock block.
// Assumes: One clock (pclk, 20 MHz), APB register access.
// Notes:   Register offsets are byte addresses on a 32-bit APB bus.
package perp_lock_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_PERP    = 8'h00; // Perpendicular mode cmd
    localparam logic [7:0] OFS_CONFIG  = 8'h04; // Configure settings
    localparam logic [7:0] OFS_LOCK    = 8'h08; // Lock cmd / result
    localparam logic [7:0] OFS_CTRL    = 8'h0c; // Reset, rate, drive, op
    localparam logic [7:0] OFS_STATUS  = 8'h10; // Live outputs
    localparam logic [7:0] OFS_DUMP8   = 8'h14; // Dump byte eight
    localparam logic [7:0] OFS_GAPCNT  = 8'h18; // Gap byte counter
    // Perpendicular register fields
    localparam int PB_WRITE_GATE_MODE_BIT = 0;
    localparam int PB_GAP   = 1;
    localparam int PB_DRV   = 2;  // Four per-drive bits [5:2]
    localparam int PB_OW    = 7;
    // Configure register fields
    localparam int CB_FIFO_DIS = 0;
    localparam int CB_THR      = 8;  // [11:8]
    localparam int CB_TRK      = 16; // [23:16]
    localparam int CB_FORCE_WP = 24;
    localparam int CB_IDENT    = 25;
    localparam int CB_ENC      = 26;
    // Control register fields
    localparam int XB_SOFT_RST = 0;  // Self-clearing
    localparam int XB_RATE     = 1;  // [2:1]
    localparam int XB_DRIVE    = 4;  // [5:4]
    localparam int XB_START_RD = 8;  // Self-clearing
    localparam int XB_START_WR = 9;  // Self-clearing
    localparam int XB_PRECOMP  = 12; // [14:12]
    // Defaults
    localparam logic       FIFO_DIS_DEF = 1'b1;
    localparam logic [3:0] THR_DEF      = 4'h0; // One byte
    localparam logic [7:0] TRK_DEF      = 8'h00;
    // Data rate codes
    localparam logic [1:0] RATE_500K = 2'h0;
    localparam logic [1:0] RATE_1M   = 2'h3;
    // Gap2 byte figures
    localparam logic [5:0] GAP2_CONV   = 6'd22;
    localparam logic [5:0] GAP2_PERP1M = 6'd41;
    localparam logic [5:0] VCO_CONV    = 6'd24;
    localparam logic [5:0] VCO_PERP1M  = 6'd43;
    localparam logic [5:0] WR_PERP1M   = 6'd38;
    localparam logic [5:0] WR_PERP500K = 6'd19;
    localparam logic [5:0] WR_NONE     = 6'd0;
    // Byte time: 8 bits at 1 Mbps = 8000 ns; cycles at 50 ns period
    localparam int BYTE_NS_1M  = 8000;
    localparam int CLK_NS      = 50;
    localparam int BYTE_CYC_1M = BYTE_NS_1M / CLK_NS;
    localparam logic [8:0] BYTE_CYC = 9'(BYTE_CYC_1M);
    localparam logic [1:0] NUM_DRV_M1 = 2'h3;
    // Operation sequence states
    typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_e;
endpackage : perp_lock_pkg

// ### rtl/gap_timer.sv
// Purpose: Computes Gap2 timing figures for one access.
// Assumes: Mode inputs stable while a count runs.
// Notes:   Registered outputs; one cycle of latency.
`timescale 1ns/1ps
module gap_timer
    import perp_lock_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       perp_1m,   // Effective 1 Mbps perpendicular
    input  wire logic       perp_500k, // Effective 500 Kbps perpendicular
    output logic      [5:0] gap_len,   // Formatted Gap2 length
    output logic      [5:0] vco_at,    // Read: VCO enable byte
    output logic      [5:0] wr_at      // Write: Gap2 bytes written
);
    typedef struct packed {
        logic [5:0] gap_len;
        logic [5:0] vco_at;
        logic [5:0] wr_at;
    } st_s;
    st_s q;      // Current state
    st_s next_q; // Next state

    // Select figures from the effective mode
    always_comb begin
        next_q = q;
        next_q.gap_len = perp_1m ? GAP2_PERP1M : GAP2_CONV;
        next_q.vco_at  = perp_1m ? VCO_PERP1M : VCO_CONV;
        if (perp_1m) begin
            next_q.wr_at = WR_PERP1M;
        end else if (perp_500k) begin
            next_q.wr_at = WR_PERP500K;
        end else begin
            next_q.wr_at = WR_NONE;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{GAP2_CONV, VCO_CONV, WR_NONE};
        end else begin
            q <= next_q;
        end
    end

    assign gap_len = q.gap_len;
    assign vco_at  = q.vco_at;
    assign wr_at   = q.wr_at;

    a_gap_len_1m: assert property (@(posedge pclk)
        disable iff (!presetn)
        perp_1m |=> gap_len == GAP2_PERP1M)
        else $error("gap length wrong in 1M perpendicular");
endmodule : gap_timer

// ### verif/drive_model.sv
// Purpose: Behavioural floppy drive on the far side of the block.
// Assumes: Write protect pins are low active and driven at all times.
// Notes:   The bench sets the protect tabs; the model drives the pins.
`timescale 1ns/1ps
module drive_model (
    input  wire logic pclk,                  // Bench clock
    input  wire logic write_gate,            // Head write enable
    input  wire logic protect,               // Native drive tab closed
    input  wire logic pp_protect,            // Parallel-port drive tab
    output logic      write_protect_input_n, // Native pin, low active
    output logic      pp_write_protect_n     // Parallel-port pin
);
    int bytes_on_head; // Cycles spent with the head writing

    // Pins follow the tabs at once, as a mechanical switch does
    assign write_protect_input_n = ~protect;
    assign pp_write_protect_n    = ~pp_protect;

    // Head activity, kept for waveform inspection only
    always @(posedge pclk) begin
        if (write_gate === 1'b1) begin
            bytes_on_head <= bytes_on_head + 1;
        end
    end
endmodule : drive_model

// ### verif/fdc_perpendicular_and_lock_tb_top.sv
// Purpose: Self-checking bench for the perpendicular and lock block.
// Assumes: Zero-wait APB slave; byte time of BYTE_CYC_1M clocks.
// Notes:   Gap timing is judged in whole byte times from the start.
`timescale 1ns/1ps
module fdc_perpendicular_and_lock_tb_top
    import perp_lock_pkg::*;
;
    typedef struct packed {
        logic [7:0] perp; // Mode register value
        logic [1:0] rate; // Data rate code
        logic [1:0] drv;  // Selected drive
        logic       wr;   // Write when set, else read
        logic [5:0] exp;  // Expected byte of the edge
    } mode_s;
    logic        pclk = 1'b0;       // 20 MHz clock
    logic        presetn = 1'b0;    // Reset, low active
    logic        psel = 1'b0;       // APB select
    logic        penable = 1'b0;    // APB access phase
    logic        pwrite = 1'b0;     // APB direction
    logic [7:0]  paddr = 8'h00;     // APB address
    logic [31:0] pwdata = 32'h0;    // APB write data
    logic [31:0] prdata;            // APB read data
    logic        pready;            // APB ready
    logic        pslverr;           // APB error
    logic        protect = 1'b0;    // Native tab
    logic        pp_protect = 1'b0; // Parallel-port tab
    logic        wp_n;              // Native pin
    logic        pp_wp_n;           // Parallel-port pin
    logic        write_protect;     // Effective protect
    logic        pll_vco_enable;    // Read PLL enable
    logic        write_gate;        // Write gate
    logic [2:0]  precomp_value;     // Applied precomp
    logic        fifo_disable_setting;
    logic [3:0]  fifo_threshold_setting;
    logic [7:0]  precomp_start_track;
    logic [31:0] rd_data;           // Last read word
    logic        last_err;          // Last pslverr
    int          fail_count = 0;    // Mismatches
    int          total_checks = 0;  // Comparisons
    int          cycles = 0;        // Timeout counter
    int          n;                 // Measured cycles
    mode_s       tbl [8] = '{
        '{8'h80, RATE_1M, 2'h0, 1'b0, VCO_CONV},   // Conventional read
        '{8'h83, RATE_1M, 2'h0, 1'b0, VCO_PERP1M}, // 1M perpendicular read
        '{8'h80, RATE_1M, 2'h0, 1'b1, 6'd22},      // Conventional write
        '{8'h83, RATE_1M, 2'h0, 1'b1, 6'd3},       // 1M: 41 less 38
        '{8'h81, RATE_500K, 2'h0, 1'b1, 6'd3},     // 500K: 22 less 19
        '{8'h82, RATE_1M, 2'h0, 1'b1, 6'd22},      // Reserved combination
        '{8'h88, RATE_500K, 2'h1, 1'b1, 6'd3},     // Drive 1 perpendicular
        '{8'h88, RATE_500K, 2'h0, 1'b1, 6'd22}     // Drive 0 conventional
    };

    // Free-running clock, 50 ns period
    always #25 pclk = ~pclk;

    // Hang guard
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            fail_count++;
            summarize();
        end
    end

    perp_lock i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .write_protect_input_n(wp_n),
        .pp_write_protect_n(pp_wp_n), .write_protect(write_protect),
        .pll_vco_enable(pll_vco_enable), .write_gate(write_gate),
        .precomp_value(precomp_value),
        .fifo_disable_setting(fifo_disable_setting),
        .fifo_threshold_setting(fifo_threshold_setting),
        .precomp_start_track(precomp_start_track));

    drive_model i_drive (.pclk(pclk), .write_gate(write_gate),
        .protect(protect), .pp_protect(pp_protect),
        .write_protect_input_n(wp_n), .pp_write_protect_n(pp_wp_n));

    // Counts and verdict, then the end of the run
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // One comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string m);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m,
                     got, exp);
        end
    endtask : chk

    // One APB transfer; answer taken at the edge that sees pready
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    // Register shorthands and a settle pause
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic settle();
        repeat (4) @(negedge pclk);
    endtask : settle
    task automatic hw_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    endtask : hw_reset

    initial begin
        hw_reset();
        settle();
        chk(fifo_disable_setting, 1'b1, "fifo default");
        chk(fifo_threshold_setting, THR_DEF, "thr default");
        chk(precomp_start_track, TRK_DEF, "trk default");
        chk(write_protect, 1'b0, "wp idle");
        // Each pin and the force bit raise protect
        protect <= 1'b1;
        settle();
        chk(write_protect, 1'b1, "native pin");
        protect <= 1'b0;
        pp_protect <= 1'b1;
        settle();
        chk(write_protect, 1'b1, "pport pin");
        pp_protect <= 1'b0;
        wr(OFS_CONFIG, 32'h0100_0000);
        settle();
        chk(write_protect, 1'b1, "force bit");
        // Unmapped place refuses writes and reads as zero
        wr(8'h1c, 32'hffff_ffff);
        chk(last_err, 1'b1, "unmapped write error");
        rd(8'h1c);
        chk(rd_data, 32'h0, "unmapped read");
        // Lock, configure, drive bits, soft reset
        wr(OFS_CONFIG, 32'h0020_0500);
        wr(OFS_LOCK, 32'h1);
        rd(OFS_LOCK);
        chk(rd_data[4], 1'b1, "lock result");
        wr(OFS_PERP, 32'hbf);
        rd(OFS_DUMP8);
        chk(rd_data[7:0], 8'hbf, "dump byte");
        wr(OFS_PERP, 32'h00);
        rd(OFS_DUMP8);
        chk(rd_data[7:0], 8'hbc, "no overwrite");
        wr(OFS_PERP, 32'h03);
        wr(OFS_CTRL, 32'h1);
        rd(OFS_DUMP8);
        chk(rd_data[7:0], 8'hbc, "soft reset mode");
        settle();
        chk(fifo_disable_setting, 1'b0, "locked fifo");
        chk(fifo_threshold_setting, 4'h5, "locked thr");
        chk(precomp_start_track, 8'h20, "locked trk");
        wr(OFS_LOCK, 32'h0);
        rd(OFS_LOCK);
        chk(rd_data[4], 1'b0, "unlock result");
        wr(OFS_CTRL, 32'h1);
        settle();
        chk(precomp_start_track, TRK_DEF, "unlocked trk");
        // Locked state is dropped by a hardware reset
        wr(OFS_CONFIG, 32'h0020_0500);
        wr(OFS_LOCK, 32'h1);
        hw_reset();
        rd(OFS_DUMP8);
        chk(rd_data[7:0], 8'h00, "hw reset dump");
        chk(fifo_threshold_setting, THR_DEF, "hw thr");
        // Gap2 timing for each of the eight table cases
        foreach (tbl[i]) begin
            wr(OFS_PERP, {24'h0, tbl[i].perp});
            wr(OFS_CTRL, {17'h0, 3'h5, 2'h0, tbl[i].wr, ~tbl[i].wr,
                          2'h0, tbl[i].drv, 1'b0, tbl[i].rate, 1'b0});
            n = 0;
            while ((tbl[i].wr ? write_gate : pll_vco_enable) !== 1'b1
                   && n < 8000) begin
                @(negedge pclk);
                n++;
            end
            chk(32'(n / BYTE_CYC_1M), 32'(tbl[i].exp), "edge byte");
            if (i == 6) chk(precomp_value, 3'h0, "perp precomp");
            if (i == 7) chk(precomp_value, 3'h5, "conv precomp");
            for (int k = 0; k < 100; k++) begin
                rd(OFS_STATUS);
                if (rd_data[5:4] === 2'h0) break;
                repeat (100) @(posedge pclk);
            end
        end
        summarize();
    end
endmodule : fdc_perpendicular_and_lock_tb_top
